// ### lecr_regs.sv
// lecr_regs: serial slave and control registers of the led sequencer group
// assumes open-drain scl/sda resolved outside; straps and pins asynchronous
`timescale 1ns/1ps
`default_nettype none
module lecr_regs
   import lecr_pkg::*;
#(
   parameter int unsigned STARTUP_WAIT = STARTUP_CYCLES
)
(
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_en_pin,
   input wire logic [1:0] i_addr_sel,
   input wire logic [NUM_SEQ-1:0] i_seq_busy,
   output logic o_sda_out,
   output logic o_sda_oe,
   output logic o_log_dim_en,
   output logic o_chip_en,
   output logic o_startup_busy,
   output logic [7:0] o_blue_duty,
   output logic [7:0] o_green_duty,
   output logic [7:0] o_red_duty,
   output logic [7:0] o_blue_drive_level,
   output logic [NUM_SEQ-1:0] o_seq_issue,
   output logic [NUM_SEQ-1:0] o_seq_pc_access,
   output logic [NUM_SEQ*PC_W-1:0] o_seq_pc,
   output logic [NUM_SEQ*2-1:0] o_seq_op_select
);
   localparam int unsigned ST_W = $clog2(STARTUP_WAIT + 1);
   localparam int unsigned DIV_W = $clog2(SLOW_DIV_CYCLES + 1);

   if (STARTUP_WAIT < 1 || STARTUP_WAIT > 32'h00FF_FFFF)
   begin : g_bad_startup
      $error("startup wait out of range");
   end

   // pin synchronisers: [0] meta, [1] stable, [2] previous
   logic [2:0] scl_pipe;
   logic [2:0] sda_pipe;
   logic [1:0] en_pipe;
   logic [1:0] asel_meta;
   logic [1:0] asel_sync;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         scl_pipe <= 3'h7;
         sda_pipe <= 3'h7;
         en_pipe <= 2'h0;
         asel_meta <= 2'h0;
         asel_sync <= 2'h0;
      end
      else
      begin
         scl_pipe <= {scl_pipe[1:0], i_scl};
         sda_pipe <= {sda_pipe[1:0], i_sda};
         en_pipe <= {en_pipe[0], i_en_pin};
         asel_meta <= i_addr_sel;
         asel_sync <= asel_meta;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic sda_bit;
   logic en_pin_hi;
   logic [6:0] own_addr;

   assign scl_rise = scl_pipe[1] & ~scl_pipe[2];
   assign scl_fall = ~scl_pipe[1] & scl_pipe[2];
   assign start_cond = scl_pipe[1] & scl_pipe[2] & sda_pipe[2] & ~sda_pipe[1];
   assign stop_cond = scl_pipe[1] & scl_pipe[2] & ~sda_pipe[2] & sda_pipe[1];
   assign sda_bit = sda_pipe[1];
   assign en_pin_hi = en_pipe[1];
   assign own_addr = {I2C_ADDR_HI, asel_sync};

   // register storage
   logic [7:0] chip_and_engine_enable;
   logic [7:0] engine_operation_select;
   logic [7:0] blue_direct_duty;
   logic [7:0] green_direct_duty;
   logic [7:0] red_direct_duty;
   logic [7:0] blue_drive_level;

   // serial slave
   lecr_i2c_state_e state;
   logic [3:0] bit_cnt;
   logic [7:0] rx_sr;
   logic [7:0] tx_sr;
   logic [7:0] ptr;
   logic ptr_phase;
   logic rd_req;
   logic master_nack;
   logic wr_stb;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_data;

   always_comb
   begin
      rd_data = 8'h00;
      case (ptr)
         REG_ENABLE: rd_data = chip_and_engine_enable;
         REG_OPSEL: rd_data = engine_operation_select;
         REG_BLUE_DUTY: rd_data = blue_direct_duty;
         REG_GREEN_DUTY: rd_data = green_direct_duty;
         REG_RED_DUTY: rd_data = red_direct_duty;
         REG_BLUE_LEVEL: rd_data = blue_drive_level;
         default: rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      wr_stb <= 1'b0;
      if (i_srst)
      begin
         state <= I2C_IDLE;
         bit_cnt <= 4'h0;
         rx_sr <= 8'h00;
         tx_sr <= 8'h00;
         ptr <= 8'h00;
         ptr_phase <= 1'b0;
         rd_req <= 1'b0;
         master_nack <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
      end
      else if (stop_cond)
         state <= I2C_IDLE;
      else if (start_cond)
      begin
         state <= I2C_ADDR;
         bit_cnt <= 4'h0;
      end
      else
         case (state)
            I2C_IDLE:
               bit_cnt <= 4'h0;
            I2C_ADDR:
               if (scl_rise)
               begin
                  rx_sr <= {rx_sr[6:0], sda_bit};
                  bit_cnt <= 4'(bit_cnt + 4'h1);
               end
               else if (scl_fall && bit_cnt == 4'h8)
               begin
                  bit_cnt <= 4'h0;
                  rd_req <= rx_sr[0];
                  if (rx_sr[7:1] == own_addr)
                     state <= I2C_ADDR_ACK;
                  else
                     state <= I2C_IDLE;
               end
            I2C_ADDR_ACK:
               if (scl_fall)
               begin
                  if (rd_req)
                  begin
                     tx_sr <= rd_data;
                     ptr <= 8'(ptr + 8'h01);
                     state <= I2C_TX;
                  end
                  else
                  begin
                     ptr_phase <= 1'b1;
                     state <= I2C_RX;
                  end
               end
            I2C_RX:
               if (scl_rise)
               begin
                  rx_sr <= {rx_sr[6:0], sda_bit};
                  bit_cnt <= 4'(bit_cnt + 4'h1);
               end
               else if (scl_fall && bit_cnt == 4'h8)
               begin
                  bit_cnt <= 4'h0;
                  state <= I2C_RX_ACK;
                  if (ptr_phase)
                     ptr <= rx_sr;
                  else
                  begin
                     wr_stb <= 1'b1;
                     wr_addr <= ptr;
                     wr_data <= rx_sr;
                     ptr <= 8'(ptr + 8'h01);
                  end
               end
            I2C_RX_ACK:
               if (scl_fall)
               begin
                  ptr_phase <= 1'b0;
                  state <= I2C_RX;
               end
            I2C_TX:
               if (scl_rise)
                  bit_cnt <= 4'(bit_cnt + 4'h1);
               else if (scl_fall)
               begin
                  if (bit_cnt == 4'h8)
                  begin
                     bit_cnt <= 4'h0;
                     state <= I2C_TX_ACK;
                  end
                  else
                     tx_sr <= {tx_sr[6:0], 1'b0};
               end
            I2C_TX_ACK:
               if (scl_rise)
                  master_nack <= sda_bit;
               else if (scl_fall)
               begin
                  if (master_nack)
                     state <= I2C_IDLE;
                  else
                  begin
                     tx_sr <= rd_data;
                     ptr <= 8'(ptr + 8'h01);
                     state <= I2C_TX;
                  end
               end
            default:
               state <= I2C_IDLE;
         endcase
   end

   // open-drain data drive: only ever pulls low
   always_ff @(posedge i_clk_sys)
   begin
      o_sda_out <= 1'b0;
      if (i_srst)
         o_sda_oe <= 1'b0;
      else
         o_sda_oe <= (state == I2C_ADDR_ACK) || (state == I2C_RX_ACK) ||
                     (state == I2C_TX && !tx_sr[7]);
   end

   // enable register: host write beats the hardware return to hold
   logic [NUM_SEQ-1:0] seq_clear;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
         chip_and_engine_enable <= ENABLE_RST;
      else
      begin
         for (int i = 0; i < NUM_SEQ; i++)
            if (seq_clear[i])
               chip_and_engine_enable[SEQ1_FIELD_LSB - SEQ_FIELD_STEP*i +: 2]
                  <= RUN_HOLD;
         if (wr_stb && wr_addr == REG_ENABLE)
            chip_and_engine_enable <= wr_data;
         if (!en_pin_hi)
            chip_and_engine_enable[CHIP_EN_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
         engine_operation_select <= OPSEL_RST;
      else if (wr_stb && wr_addr == REG_OPSEL)
         engine_operation_select <= wr_data & OPSEL_MASK;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         blue_direct_duty <= DUTY_RST;
         green_direct_duty <= DUTY_RST;
         red_direct_duty <= DUTY_RST;
         blue_drive_level <= LEVEL_RST;
      end
      else if (wr_stb)
         case (wr_addr)
            REG_BLUE_DUTY: blue_direct_duty <= wr_data;
            REG_GREEN_DUTY: green_direct_duty <= wr_data;
            REG_RED_DUTY: red_direct_duty <= wr_data;
            REG_BLUE_LEVEL: blue_drive_level <= wr_data;
            default: blue_drive_level <= blue_drive_level;
         endcase
   end

   // startup wait after the master enable rises
   logic chip_en_prev;
   logic [ST_W-1:0] startup_cnt;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         chip_en_prev <= 1'b0;
         startup_cnt <= '0;
         o_startup_busy <= 1'b0;
      end
      else
      begin
         chip_en_prev <= chip_and_engine_enable[CHIP_EN_BIT];
         if (!chip_and_engine_enable[CHIP_EN_BIT])
         begin
            startup_cnt <= '0;
            o_startup_busy <= 1'b0;
         end
         else if (!chip_en_prev)
         begin
            startup_cnt <= ST_W'(STARTUP_WAIT - 1);
            o_startup_busy <= 1'b1;
         end
         else if (startup_cnt != '0)
            startup_cnt <= ST_W'(startup_cnt - 1'b1);
         else
            o_startup_busy <= 1'b0;
      end
   end

   // slow tick divider
   logic [DIV_W-1:0] div_cnt;
   logic slow_tick;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         div_cnt <= '0;
         slow_tick <= 1'b0;
      end
      else if (div_cnt == DIV_W'(SLOW_DIV_CYCLES - 1))
      begin
         div_cnt <= '0;
         slow_tick <= 1'b1;
      end
      else
      begin
         div_cnt <= DIV_W'(div_cnt + 1'b1);
         slow_tick <= 1'b0;
      end
   end

   logic seq_ready;
   assign seq_ready = chip_and_engine_enable[CHIP_EN_BIT] & ~o_startup_busy;

   for (genvar g = 0; g < NUM_SEQ; g++)
   begin : g_seq
      localparam int unsigned LSB = SEQ1_FIELD_LSB - SEQ_FIELD_STEP*g;
      lecr_seq_ctrl u_seq (
         .i_clk_sys(i_clk_sys),
         .i_srst(i_srst),
         .i_tick(slow_tick),
         .i_ready(seq_ready),
         .i_run_ctrl(chip_and_engine_enable[LSB +: 2]),
         .i_op_select(engine_operation_select[LSB +: 2]),
         .i_instr_busy(i_seq_busy[g]),
         .o_issue(o_seq_issue[g]),
         .o_clear_req(seq_clear[g]),
         .o_pc_access(o_seq_pc_access[g]),
         .o_pc(o_seq_pc[g*PC_W +: PC_W]),
         .o_op_sync(o_seq_op_select[g*2 +: 2])
      );
   end

   assign o_log_dim_en = chip_and_engine_enable[LOG_DIM_BIT];
   assign o_chip_en = chip_and_engine_enable[CHIP_EN_BIT];
   assign o_blue_duty = blue_direct_duty;
   assign o_green_duty = green_direct_duty;
   assign o_red_duty = red_direct_duty;
   assign o_blue_drive_level = blue_drive_level;
endmodule
`default_nettype wire

// ### lecr_pkg.sv
// lecr_pkg: constants and types for the led engine control register group
// assumes a 40 MHz system clock and a two-wire serial host
package lecr_pkg;
   localparam int unsigned SYS_CLK_HZ = 40_000_000;
   localparam int unsigned SLOW_CLK_HZ = 32_768;
   localparam int unsigned SLOW_DIV_CYCLES = SYS_CLK_HZ / SLOW_CLK_HZ;
   localparam int unsigned STARTUP_DELAY_US = 500;
   localparam int unsigned STARTUP_CYCLES =
      (SYS_CLK_HZ / 1_000_000) * STARTUP_DELAY_US;
   localparam int unsigned ENABLE_WRITE_GAP_US = 488;
   localparam int unsigned OPSEL_WRITE_GAP_US = 153;
   localparam int unsigned NUM_SEQ = 3;
   localparam int unsigned PC_W = 4;

   localparam logic [7:0] REG_ENABLE = 8'h00;
   localparam logic [7:0] REG_OPSEL = 8'h01;
   localparam logic [7:0] REG_BLUE_DUTY = 8'h02;
   localparam logic [7:0] REG_GREEN_DUTY = 8'h03;
   localparam logic [7:0] REG_RED_DUTY = 8'h04;
   localparam logic [7:0] REG_BLUE_LEVEL = 8'h05;

   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [7:0] OPSEL_RST = 8'h00;
   localparam logic [7:0] DUTY_RST = 8'h00;
   localparam logic [7:0] LEVEL_RST = 8'hAF;
   localparam logic [7:0] OPSEL_MASK = 8'h3F;

   localparam int unsigned LOG_DIM_BIT = 7;
   localparam int unsigned CHIP_EN_BIT = 6;
   localparam int unsigned SEQ1_FIELD_LSB = 4;
   localparam int unsigned SEQ_FIELD_STEP = 2;

   localparam logic [1:0] RUN_HOLD = 2'h0;
   localparam logic [1:0] RUN_STEP = 2'h1;
   localparam logic [1:0] RUN_FREE = 2'h2;
   localparam logic [1:0] RUN_ONCE = 2'h3;
   localparam logic [1:0] OP_OFF = 2'h0;
   localparam logic [1:0] OP_LOAD = 2'h1;
   localparam logic [1:0] OP_RUN = 2'h2;
   localparam logic [1:0] OP_DIRECT = 2'h3;

   // upper five bits of the serial address; value is arbitrary
   localparam logic [4:0] I2C_ADDR_HI = 5'h0C;

   typedef enum logic [2:0] {
      I2C_IDLE = 3'h0,
      I2C_ADDR = 3'h1,
      I2C_ADDR_ACK = 3'h3,
      I2C_RX = 3'h2,
      I2C_RX_ACK = 3'h6,
      I2C_TX = 3'h7,
      I2C_TX_ACK = 3'h5
   } lecr_i2c_state_e;

   typedef enum logic {
      SQ_HOLD = 1'b0,
      SQ_BUSY = 1'b1
   } lecr_seq_state_e;
endpackage

// ### lecr_seq_ctrl.sv
// lecr_seq_ctrl: run control of one program sequencer
// assumes a one-cycle slow tick and a busy flag from the instruction core
`timescale 1ns/1ps
`default_nettype none
module lecr_seq_ctrl
   import lecr_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic i_tick,
   input wire logic i_ready,
   input wire logic [1:0] i_run_ctrl,
   input wire logic [1:0] i_op_select,
   input wire logic i_instr_busy,
   output logic o_issue,
   output logic o_clear_req,
   output logic o_pc_access,
   output logic [PC_W-1:0] o_pc,
   output logic [1:0] o_op_sync
);
   logic [1:0] run_sync;
   logic [1:0] run_active;
   lecr_seq_state_e state;

   // fields only take effect on the slow tick
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         run_sync <= RUN_HOLD;
         o_op_sync <= OP_OFF;
      end
      else if (i_tick)
      begin
         run_sync <= i_run_ctrl;
         o_op_sync <= i_op_select;
      end
      // a finished step or once drops the stale sample at once, so the
      // next tick cannot start the same instruction a second time
      else if (o_clear_req)
         run_sync <= RUN_HOLD;
   end

   always_ff @(posedge i_clk_sys)
   begin
      o_issue <= 1'b0;
      o_clear_req <= 1'b0;
      if (i_srst)
      begin
         state <= SQ_HOLD;
         run_active <= RUN_HOLD;
         o_pc <= '0;
      end
      else if (o_op_sync == OP_LOAD)
      begin
         state <= SQ_HOLD;
         o_pc <= '0;
      end
      else if (!i_ready || o_op_sync != OP_RUN)
         state <= SQ_HOLD;
      else if (i_tick)
         case (state)
            SQ_HOLD:
               if (run_sync != RUN_HOLD)
               begin
                  o_issue <= 1'b1;
                  run_active <= run_sync;
                  state <= SQ_BUSY;
               end
            SQ_BUSY:
               // in run mode with i_ready set, the current instruction always completes first
               if (!i_instr_busy)
               begin
                  state <= SQ_HOLD;
                  if (run_active != RUN_ONCE)
                     o_pc <= PC_W'(o_pc + 1'b1);
                  if (run_active != RUN_FREE)
                     o_clear_req <= 1'b1;
               end
            default:
               state <= SQ_HOLD;
         endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
         o_pc_access <= 1'b1;
      else
         o_pc_access <= (run_sync == RUN_HOLD) && (state == SQ_HOLD);
   end
endmodule
`default_nettype wire

// ### lecr_regs_checker.sv
// lecr_regs_checker: port assertions for the led control registers
// assumes it is bound into lecr_regs; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module lecr_regs_checker
   import lecr_pkg::*;
#(
   parameter int unsigned STARTUP_WAIT = STARTUP_CYCLES
)
(
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic i_en_pin,
   input wire logic o_chip_en,
   input wire logic o_startup_busy,
   input wire logic [7:0] o_blue_drive_level,
   input wire logic [NUM_SEQ-1:0] o_seq_issue,
   input wire logic [NUM_SEQ-1:0] o_seq_pc_access,
   input wire logic [NUM_SEQ*PC_W-1:0] o_seq_pc,
   input wire logic [NUM_SEQ*2-1:0] o_seq_op_select
);
   int unsigned busy_cnt;
   logic [15:0] gap3;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_srst);
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst || !o_startup_busy)
         busy_cnt <= 0;
      else
         busy_cnt <= busy_cnt + 1;
   end
   // cycles since the last issue of sequencer 3, saturating
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
         gap3 <= 16'hFFFF;
      else if (o_seq_issue[2])
         gap3 <= 16'h0001;
      else if (gap3 != 16'hFFFF)
         gap3 <= gap3 + 16'h0001;
   end
   sequence s_pin_low;
      !i_en_pin [*4];
   endsequence
   sequence s_seq3_load;
      (o_seq_op_select[5:4] == OP_LOAD) [*2];
   endsequence
   a_reset_values:
      assert property ($fell(i_srst) |-> o_blue_drive_level == LEVEL_RST
         && o_seq_pc_access == 3'h7)
      else $error("values after reset wrong");
   a_pin_clears:
      assert property (s_pin_low |-> !o_chip_en)
      else $error("chip enable kept with pin low");
   a_startup_rise:
      assert property ($rose(o_chip_en) |-> ##[0:1] o_startup_busy)
      else $error("no startup wait on enable");
   a_startup_len:
      assert property ($fell(o_startup_busy) && o_chip_en |->
         busy_cnt + 1 >= STARTUP_WAIT && busy_cnt <= STARTUP_WAIT + 1)
      else $error("startup wait length wrong");
   a_issue_single:
      assert property (o_seq_issue[0] |=> !o_seq_issue[0] [*8])
      else $error("issue pulse too long");
   a_issue_spacing:
      assert property (o_seq_issue[2] |-> gap3 >= 16'h04C3)
      else $error("issues closer than one slow tick");
   a_issue_needs_run:
      assert property (o_seq_issue[0] |->
         o_seq_op_select[1:0] == OP_RUN && $past(o_chip_en))
      else $error("issue without run mode");
   a_no_access_busy:
      assert property (o_seq_issue[0] |-> ##[0:1] !o_seq_pc_access[0])
      else $error("counter open while executing");
   a_load_pc_zero:
      assert property (s_seq3_load |-> o_seq_pc[11:8] == 4'h0)
      else $error("counter not cleared in load");
   a_idle_no_issue:
      assert property ((o_seq_op_select[5:4] != OP_RUN) [*2] |->
         !o_seq_issue[2])
      else $error("issue outside run mode");
endmodule
bind lecr_regs lecr_regs_checker #(.STARTUP_WAIT(STARTUP_WAIT)) u_chk (
   .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_en_pin(i_en_pin),
   .o_chip_en(o_chip_en), .o_startup_busy(o_startup_busy),
   .o_blue_drive_level(o_blue_drive_level), .o_seq_issue(o_seq_issue),
   .o_seq_pc_access(o_seq_pc_access), .o_seq_pc(o_seq_pc),
   .o_seq_op_select(o_seq_op_select));
`default_nettype wire

// ### lecr_host_model.sv
// lecr_host_model: two-wire host that reads and writes the registers
// assumes the bench resolves sda as a pulled-up wired-and; scl is ours
`timescale 1ns/1ps
`default_nettype none
module lecr_host_model
   import lecr_pkg::*;
#(
   parameter int unsigned HOLD_OFF = STARTUP_CYCLES,
   parameter logic [6:0] DEV = 7'h60
)
(
   input wire logic i_clk_sys,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   localparam int EN_GAP = ENABLE_WRITE_GAP_US * 40 + 1;
   localparam int OP_GAP = OPSEL_WRITE_GAP_US * 40 + 1;
   int cyc = 0;
   int last_en = -100000;
   int last_op = -100000;
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   always @(posedge i_clk_sys)
      cyc <= cyc + 1;
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   // scl high lasts 6 cycles and scl low 12, sda moves mid low phase
   task automatic bit_io(input logic b, output logic r);
      o_sda_low <= !b;
      wt(6);
      o_scl <= 1'b1;
      wt(3);
      r = i_sda;
      wt(3);
      o_scl <= 1'b0;
      wt(6);
   endtask
   task automatic start_c();
      o_scl <= 1'b1;
      wt(6);
      o_sda_low <= 1'b1;
      wt(6);
      o_scl <= 1'b0;
      wt(6);
   endtask
   task automatic stop_c();
      o_sda_low <= 1'b1;
      wt(6);
      o_scl <= 1'b1;
      wt(6);
      o_sda_low <= 1'b0;
      wt(6);
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] q,
      output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic write_reg(input logic [7:0] p, input logic [7:0] d,
      output logic ok);
      logic [7:0] q;
      logic a0;
      logic a1;
      logic a2;
      while (p == REG_ENABLE && cyc - last_en < EN_GAP)
         wt(1);
      while (p == REG_OPSEL && cyc - last_op < OP_GAP)
         wt(1);
      start_c();
      xfer({DEV, 1'b0}, q, a0);
      xfer(p, q, a1);
      xfer(d, q, a2);
      stop_c();
      ok = a0 && a1 && a2;
      if (p == REG_ENABLE)
         last_en = cyc;
      if (p == REG_OPSEL)
         last_op = cyc;
      if (p == REG_ENABLE && d[CHIP_EN_BIT])
         wt(HOLD_OFF);
   endtask
   task automatic read_reg(input logic [7:0] p, output logic [7:0] q,
      output logic ok);
      logic [7:0] x;
      logic a0;
      logic a1;
      logic a2;
      logic nack;
      start_c();
      xfer({DEV, 1'b0}, x, a0);
      xfer(p, x, a1);
      start_c();
      xfer({DEV, 1'b1}, x, a2);
      xfer(8'hFF, q, nack);
      stop_c();
      ok = a0 && a1 && a2;
   endtask
endmodule
`default_nettype wire

// ### lecr_regs_tb.sv
// lecr_regs_tb: self-checking bench for the led control registers
// assumes host model and checker are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module lecr_regs_tb
   import lecr_pkg::*;
;
   localparam int unsigned SIM_WAIT = 20;
   localparam int TICKS3 = 3700;
   logic i_clk_sys = 1'b0;
   logic i_srst = 1'b1;
   logic i_en_pin = 1'b1;
   logic [2:0] seq_busy = 3'h0;
   logic scl;
   logic host_low;
   logic sda_out;
   logic sda_oe;
   logic log_dim;
   logic chip_en;
   logic busy;
   logic [7:0] blue;
   logic [7:0] green;
   logic [7:0] red;
   logic [7:0] level;
   logic [2:0] issue;
   logic [2:0] access;
   logic [11:0] pc;
   logic [5:0] opsel;
   wire logic sda;
   int fail_count = 0;
   int total_checks = 0;
   assign sda = !(host_low || (sda_oe && !sda_out));
   lecr_regs #(.STARTUP_WAIT(SIM_WAIT)) u_dut (
      .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_scl(scl), .i_sda(sda),
      .i_en_pin(i_en_pin), .i_addr_sel(2'h2), .i_seq_busy(seq_busy),
      .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_log_dim_en(log_dim),
      .o_chip_en(chip_en), .o_startup_busy(busy), .o_blue_duty(blue),
      .o_green_duty(green), .o_red_duty(red), .o_blue_drive_level(level),
      .o_seq_issue(issue), .o_seq_pc_access(access), .o_seq_pc(pc),
      .o_seq_op_select(opsel));
   lecr_host_model #(.HOLD_OFF(SIM_WAIT), .DEV({I2C_ADDR_HI, 2'h2})) u_host (
      .i_clk_sys(i_clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
   initial
      forever #12.5 i_clk_sys = ~i_clk_sys;
   task automatic close_out();
      $display("checks %0d failures %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      logic [7:0] q;
      logic ok;
      u_host.read_reg(p, q, ok);
      chk({7'h00, ok, q}, {8'h01, e});
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic ok;
      u_host.write_reg(p, d, ok);
      chk({15'h0000, ok}, 16'h0001);
   endtask
   task automatic t_reset();
      logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hAF, 8'h00};
      chk({13'h0000, access}, 16'h0007);
      for (int i = 0; i < 7; i++)
         rd(8'(i), rv[i]);
      $display("test reset_values done");
   endtask
   task automatic t_duty();
      wr(REG_BLUE_DUTY, 8'h5A);
      wr(REG_GREEN_DUTY, 8'hA5);
      wr(REG_RED_DUTY, 8'h3C);
      wr(REG_BLUE_LEVEL, 8'hFF);
      chk({blue, green}, 16'h5AA5);
      chk({red, level}, 16'h3CFF);
      rd(REG_GREEN_DUTY, 8'hA5);
      rd(REG_BLUE_LEVEL, 8'hFF);
      $display("test duty_regs done");
   endtask
   // seq1 steps, seq2 runs once, seq3 runs freely; seq1 core busy at first
   task automatic t_run();
      seq_busy <= 3'h1;
      wr(REG_OPSEL, 8'h2A);
      wr(REG_ENABLE, 8'hDE);
      chk({14'h0000, log_dim, chip_en}, 16'h0003);
      repeat (6100) @(posedge i_clk_sys);
      rd(REG_ENABLE, 8'hD2);
      chk({8'h00, pc[7:0]}, 16'h0000);
      chk({13'h0000, access}, 16'h0002);
      seq_busy <= 3'h0;
      repeat (2500) @(posedge i_clk_sys);
      rd(REG_ENABLE, 8'hC2);
      chk({8'h00, pc[7:0]}, 16'h0001);
      chk({15'h0000, pc[11:8] == 4'h0}, 16'h0000);
      chk({10'h000, opsel}, 16'h002A);
      chk({13'h0000, access}, 16'h0003);
      $display("test run_codes done");
   endtask
   task automatic t_opsel();
      wr(REG_OPSEL, 8'h29);
      repeat (TICKS3) @(posedge i_clk_sys);
      // output order is seq3, seq2, seq1 from the top
      chk({6'h00, opsel, pc[11:8]}, 16'h01A0);
      wr(REG_OPSEL, 8'hFF);
      rd(REG_OPSEL, OPSEL_MASK);
      repeat (TICKS3) @(posedge i_clk_sys);
      chk({10'h000, opsel}, 16'h003F);
      $display("test op_modes done");
   endtask
   task automatic t_pin();
      i_en_pin <= 1'b0;
      repeat (8) @(posedge i_clk_sys);
      chk({15'h0000, chip_en}, 16'h0000);
      rd(REG_ENABLE, 8'h82);
      $display("test pin_clear done");
   endtask
   initial
   begin
      repeat (6) @(posedge i_clk_sys);
      i_srst <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      t_reset();
      t_duty();
      t_run();
      t_opsel();
      t_pin();
      close_out();
   end
   initial
   begin
      repeat (100000) @(posedge i_clk_sys);
      fail_count++;
      close_out();
   end
endmodule
`default_nettype wire
